// ===== rtl/module_gate.sv
/*
 * Per-module disable gate: clock enable, held reset, wake-up delay and
 * gating of the module's own register writes and read data.
 * Assumes the disable level comes from a register on the same clock.
 */
module module_gate
    import pin_route_pkg::*;
#(
    parameter logic [3:0] WAKE = 4'(WAKE_CYCLES)
)
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic disable_i,
    // Module register access from the core
    input wire logic sfr_wr_i,
    input wire logic [DATA_W-1:0] sfr_rdata_i,
    // Towards the module, plus ready and gated read data for the core
    output logic clk_en_o,
    output logic mod_rst_n_o,
    output logic ready_o,
    output logic sfr_wr_o,
    output logic [DATA_W-1:0] sfr_rdata_o
);
    localparam int WAKE_I = int'(WAKE);

    typedef struct packed {
        logic clk_en;
        logic mod_rst_n;
        logic ready;
        logic [3:0] cnt;
        logic sfr_wr;
        logic [DATA_W-1:0] sfr_rdata;
    } state_t;

    state_t st;
    state_t next_st;

    // Disable stops everything; enable counts the wake-up time
    always_comb
    begin
        next_st = st;
        if (disable_i)
        begin
            next_st.clk_en = 1'b0; // [R6] [R12]
            next_st.mod_rst_n = 1'b0; // [R7]
            next_st.ready = 1'b0;
            next_st.cnt = 4'h0;
            next_st.sfr_wr = 1'b0; // [R7]
            next_st.sfr_rdata = 8'h00; // [R7]
        end
        else
        begin
            next_st.clk_en = 1'b1;
            next_st.mod_rst_n = 1'b1; // [R8]
            if (st.cnt < WAKE)
            begin
                next_st.cnt = st.cnt + 4'h1;
            end
            next_st.ready = (next_st.cnt == WAKE); // [R9]
            next_st.sfr_wr = sfr_wr_i;
            next_st.sfr_rdata = sfr_rdata_i;
        end
    end

    // Reset holds the module in reset but clocked, as if just enabled
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st <= '{clk_en: 1'b1, mod_rst_n: 1'b0, ready: 1'b0, cnt: 4'h0,
                    sfr_wr: 1'b0, sfr_rdata: 8'h00};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign clk_en_o = st.clk_en;
    assign mod_rst_n_o = st.mod_rst_n;
    assign ready_o = st.ready;
    assign sfr_wr_o = st.sfr_wr;
    assign sfr_rdata_o = st.sfr_rdata;

    a_disable_stops_all: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [R6]
        disable_i |=> !clk_en_o && !mod_rst_n_o && !ready_o)
        else $error("disabled module still clocked or out of reset");

    a_disabled_access_dead: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [R7]
        disable_i |=> !sfr_wr_o && (sfr_rdata_o == 8'h00))
        else $error("disabled module register access not blocked");

    a_wake_timing: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [R9]
        ($fell(disable_i) ##1 !disable_i [*4]) |-> ready_o == (WAKE_I <= 4))
        else $error("wake-up delay wrong");

endmodule

// ===== rtl/pin_route_ctrl.sv
/*
 * Module disable control and pin routing lock: register port, disable
 * bits, routing lock flag, routing selection registers and per-module
 * gates for the peripheral modules.
 * Assumes a core that strobes reads and writes for one cycle each, never
 * both together, and takes read data in the cycle after the read strobe.
 * The peripherals use the clock enables through their own clock gates.
 */
module pin_route_ctrl
    import pin_route_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
)
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Register port
    input wire bus_req_t bus_i,
    output logic [DATA_W-1:0] rd_data_o,
    // Module register access from the core
    input wire logic [NUM_MODULES-1:0] sfr_wr_i,
    input wire logic [NUM_MODULES-1:0][DATA_W-1:0] sfr_rdata_i,
    // Module control
    output logic [NUM_MODULES-1:0] mod_clk_en_o,
    output logic [NUM_MODULES-1:0] mod_rst_n_o,
    output logic [NUM_MODULES-1:0] mod_ready_o,
    output logic [NUM_MODULES-1:0] sfr_wr_o,
    output logic [NUM_MODULES-1:0][DATA_W-1:0] sfr_rdata_o,
    // Routing selections
    output logic lock_o,
    output logic [NUM_IN_ROUTES-1:0][IN_SEL_W-1:0] in_sel_o,
    output logic [NUM_OUT_ROUTES-1:0][OUT_SEL_W-1:0] out_sel_o
);
    typedef struct packed {
        logic lock;
        logic [NUM_MODULES-1:0] dis;
        logic [DATA_W-1:0] rd_data;
    } state_t;

    state_t st;
    state_t next_st;

    // Per-register write strobes and holds
    logic [NUM_IN_ROUTES-1:0] in_wr;
    logic [NUM_IN_ROUTES-1:0] in_hold;
    logic [NUM_OUT_ROUTES-1:0] out_wr;
    logic [NUM_OUT_ROUTES-1:0] out_present;

    // Control registers and read mux
    always_comb
    begin
        next_st = st;
        next_st.rd_data = 8'h00;

        if (bus_i.wr)
        begin
            case (bus_i.addr)
                OFS_LOCK:
                begin
                    // Lock flag itself stays writable
                    next_st.lock = bus_i.wdata[LOCK_BIT]; // [R2] [R14]
                end
                OFS_DIS_LO:
                begin
                    next_st.dis[7:0] = bus_i.wdata; // [R13]
                end
                OFS_DIS_HI:
                begin
                    next_st.dis[NUM_MODULES-1:8] = bus_i.wdata[DIS_HI_W-1:0]; // [R13]
                end
                default:
                begin
                    next_st.dis = st.dis;
                end
            endcase
        end

        // Read data stands only in the cycle after the strobe
        if (bus_i.rd)
        begin
            case (bus_i.addr)
                OFS_LOCK:
                begin
                    next_st.rd_data = {7'h00, st.lock}; // [R2]
                end
                OFS_DIS_LO:
                begin
                    next_st.rd_data = st.dis[7:0];
                end
                OFS_DIS_HI:
                begin
                    next_st.rd_data = 8'(st.dis[NUM_MODULES-1:8]);
                end
                OFS_RDY_LO:
                begin
                    next_st.rd_data = mod_ready_o[7:0];
                end
                OFS_RDY_HI:
                begin
                    next_st.rd_data = 8'(mod_ready_o[NUM_MODULES-1:8]);
                end
                default:
                begin
                    next_st.rd_data = 8'h00;
                end
            endcase

            // Routing fields; held ones already read as zero
            for (int i = 0; i < NUM_IN_ROUTES; i++)
            begin
                if (bus_i.addr == OFS_IN_BASE + 8'(i))
                begin
                    next_st.rd_data = {2'b00, in_sel_o[i]}; // [R3]
                end
            end
            for (int j = 0; j < NUM_OUT_ROUTES; j++)
            begin
                if (bus_i.addr == OFS_OUT_BASE + 8'(j) && out_present[j])
                begin
                    next_st.rd_data = {3'b000, out_sel_o[j]}; // [R3] [R4]
                end
            end
        end
    end

    // Every reset enables all modules and unlocks routing
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st <= '{lock: RST_LOCK, dis: RST_DISABLE, rd_data: 8'h00}; // [R5] [R2]
        end
        else
        begin
            st <= next_st;
        end
    end

    assign lock_o = st.lock;
    assign rd_data_o = st.rd_data;

    // Input routing: lock and owner disable both block writes
    for (genvar gi = 0; gi < NUM_IN_ROUTES; gi++)
    begin : g_in
        if (IN_OWNER[gi] == NO_OWNER)
        begin : g_free
            // No owner module: nothing can hold this field
            assign in_hold[gi] = 1'b0;
        end
        else
        begin : g_owned
            // Owner index is only in range on this branch
            assign in_hold[gi] = st.dis[IN_OWNER[gi]]; // [R11]
        end
        assign in_wr[gi] = bus_i.wr && (bus_i.addr == OFS_IN_BASE + 8'(gi))
                           && !st.lock; // [R1] [R14]

        route_field #(
            .W(IN_SEL_W),
            .RST(RST_IN_SEL)
        ) u_in (
            .mclk_i(mclk_i),
            .rst_n_i(rst_n_i),
            .wr_i(in_wr[gi]),
            .wdata_i(bus_i.wdata[IN_SEL_W-1:0]),
            .hold_rst_i(in_hold[gi]),
            .sel_o(in_sel_o[gi])
        );
    end

    // Output routing: the second port exists only on the larger variant
    for (genvar go = 0; go < NUM_OUT_ROUTES; go++)
    begin : g_out
        if (go < NUM_OUT_A || LARGE_VARIANT)
        begin : g_on
            assign out_present[go] = 1'b1;
            assign out_wr[go] = bus_i.wr && (bus_i.addr == OFS_OUT_BASE + 8'(go))
                                && !st.lock; // [R1] [R14]

            route_field #(
                .W(OUT_SEL_W),
                .RST(RST_OUT_SEL)
            ) u_out (
                .mclk_i(mclk_i),
                .rst_n_i(rst_n_i),
                .wr_i(out_wr[go]),
                .wdata_i(bus_i.wdata[OUT_SEL_W-1:0]),
                .hold_rst_i(1'b0),
                .sel_o(out_sel_o[go])
            );
        end
        else
        begin : g_off
            // Absent pins: nothing stored, reads fall to zero
            assign out_present[go] = 1'b0; // [R4]
            assign out_wr[go] = 1'b0;
            assign out_sel_o[go] = RST_OUT_SEL;
        end
    end

    // One gate per module; the gate owns the wake-up count
    for (genvar gm = 0; gm < NUM_MODULES; gm++)
    begin : g_mod
        module_gate #(
            .WAKE(4'(WAKE_CYCLES))
        ) u_gate (
            .mclk_i(mclk_i),
            .rst_n_i(rst_n_i),
            .disable_i(st.dis[gm]), // [R6] [R7] [R8] [R12]
            .sfr_wr_i(sfr_wr_i[gm]),
            .sfr_rdata_i(sfr_rdata_i[gm]),
            .clk_en_o(mod_clk_en_o[gm]),
            .mod_rst_n_o(mod_rst_n_o[gm]),
            .ready_o(mod_ready_o[gm]),
            .sfr_wr_o(sfr_wr_o[gm]),
            .sfr_rdata_o(sfr_rdata_o[gm])
        );
    end

    // A locked write to the irq routing field leaves it untouched
    a_lock_blocks_in: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [R1]
        (st.lock && bus_i.wr && bus_i.addr == OFS_IN_BASE) |=> $stable(in_sel_o[0]))
        else $error("locked input routing changed");

    a_lock_blocks_out: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [R1]
        (st.lock && bus_i.wr && bus_i.addr == OFS_OUT_BASE) |=> $stable(out_sel_o[0]))
        else $error("locked output routing changed");

    a_unlock_writes: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [R1]
        (!st.lock && bus_i.wr && bus_i.addr == OFS_OUT_BASE)
        |=> out_sel_o[0] == $past(bus_i.wdata[OUT_SEL_W-1:0]))
        else $error("unlocked output routing write lost");

    a_lock_read_back: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [R2]
        (bus_i.rd && bus_i.addr == OFS_LOCK) |=> rd_data_o == {7'h00, $past(st.lock)})
        else $error("lock register read wrong");

    a_lock_spares_disable: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [R14]
        (st.lock && bus_i.wr && bus_i.addr == OFS_DIS_HI)
        |=> st.dis[NUM_MODULES-1:8] == $past(bus_i.wdata[DIS_HI_W-1:0]))
        else $error("lock blocked a disable bit write");

    a_read_one_cycle: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !bus_i.rd |=> rd_data_o == 8'h00)
        else $error("read data outside its cycle");

    a_disable_gates_clk: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [R13]
        (bus_i.wr && bus_i.addr == OFS_DIS_LO && bus_i.wdata[0]) |-> ##2 !mod_clk_en_o[0])
        else $error("disable bit did not stop module clock");

    a_owner_holds_route: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [R11]
        st.dis[1] |=> in_sel_o[2] == RST_IN_SEL && in_sel_o[3] == RST_IN_SEL)
        else $error("disabled module routing not held");

    a_small_port_absent: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [R4]
        (!LARGE_VARIANT && bus_i.rd && bus_i.addr >= OFS_OUT_BASE + 8'(NUM_OUT_A)
         && bus_i.addr < OFS_OUT_BASE + 8'(NUM_OUT_ROUTES))
        |=> rd_data_o == 8'h00)
        else $error("absent output routing register reads nonzero");

endmodule

// ===== rtl/pin_route_pkg.sv
/*
 * Constants, register map and carrier types for the module disable and
 * pin routing lock block.
 * Assumes one 100 MHz system clock and an 8-bit register port driven by a
 * core that never issues a read and a write in the same cycle.
 */
// How it works
// R1: Lock flag set blocks every routing selection write; clear lets them change.
// R2: Lock flag is bit 0 only, cleared by every reset, bits 7-1 read zero.
// R3: Input routing fields are 6 bits, output routing fields 5 bits, upper bits zero.
// R4: Second port output routing exists only on the larger pin-count variant.
// R5: After any reset every module disable bit is clear, so all modules run.
// R6: A set disable bit stops the module clock and control inputs.
// R7: Disabled module is held in reset, its writes dropped and reads zero.
// R8: Clearing the disable bit restarts the module from its reset values.
// R9: A re-enabled module may take up to one instruction cycle to become active.
// R10: Software should not touch a re-enabled module for one instruction.
// R11: Disabling a module also disables its input routing selection registers.
// R12: Disabling removes all switching activity inside the module.
// R13: Each module has its own disable bit: one disables, zero enables.
// R14: Lock covers input and output routing registers only, nothing else.
package pin_route_pkg;

    // Bus and field widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int IN_SEL_W = 6;
    localparam int OUT_SEL_W = 5;

    // Counts of controlled modules and routing registers
    localparam int NUM_MODULES = 10;
    localparam int DIS_HI_W = NUM_MODULES - 8;
    localparam int NUM_IN_ROUTES = 18;
    localparam int NUM_OUT_A = 6;
    localparam int NUM_OUT_C = 8;
    localparam int NUM_OUT_ROUTES = NUM_OUT_A + NUM_OUT_C;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_LOCK = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_IN_BASE = 8'h01;
    localparam logic [ADDR_W-1:0] OFS_OUT_BASE = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_DIS_LO = 8'h30;
    localparam logic [ADDR_W-1:0] OFS_DIS_HI = 8'h31;
    localparam logic [ADDR_W-1:0] OFS_RDY_LO = 8'h32;
    localparam logic [ADDR_W-1:0] OFS_RDY_HI = 8'h33;

    // Field positions and values after reset
    localparam int LOCK_BIT = 0;
    localparam logic RST_LOCK = 1'b0;
    localparam logic [IN_SEL_W-1:0] RST_IN_SEL = 6'h00;
    localparam logic [OUT_SEL_W-1:0] RST_OUT_SEL = 5'h00;
    localparam logic [NUM_MODULES-1:0] RST_DISABLE = 10'h000;

    // Wake-up time of a re-enabled module
    localparam int CLK_PERIOD_NS = 10;
    localparam int INSTR_CYCLE_NS = 40;
    localparam int WAKE_CYCLES = INSTR_CYCLE_NS / CLK_PERIOD_NS;

    // Module indices: tmr0 0, tmr1 1, tmr2 2, ccp1 3, ccp2 4, cwg 5,
    // sync serial 6, uart 7, logic cells 8, adc 9; the irq input has none
    localparam logic [3:0] NO_OWNER = 4'hf;
    localparam logic [3:0] IN_OWNER [NUM_IN_ROUTES] = '{
        4'hf, 4'h0, 4'h1, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
        4'h6, 4'h6, 4'h7, 4'h7, 4'h8, 4'h8, 4'h8, 4'h8, 4'h9
    };

    // One register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

endpackage

// ===== rtl/route_field.sv
/*
 * One pin routing selection field with write gating and held reset.
 * Assumes the write strobe is already decoded and qualified by the lock.
 */
module route_field
#(
    parameter int W = 6,
    parameter logic [W-1:0] RST = '0
)
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Write and hold
    input wire logic wr_i,
    input wire logic [W-1:0] wdata_i,
    input wire logic hold_rst_i,
    // Selection
    output logic [W-1:0] sel_o
);
    typedef struct packed {
        logic [W-1:0] sel;
    } state_t;

    state_t st;
    state_t next_st;

    // Held reset beats a write
    always_comb
    begin
        next_st = st;
        if (hold_rst_i)
        begin
            next_st.sel = RST; // [R11]
        end
        else if (wr_i)
        begin
            next_st.sel = wdata_i;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st <= '{sel: RST};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign sel_o = st.sel;

    a_hold_resets_sel: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [R11]
        hold_rst_i |=> sel_o == RST)
        else $error("held routing field not at reset value");

    a_write_lands: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (wr_i && !hold_rst_i) |=> sel_o == $past(wdata_i))
        else $error("routing field write lost");

endmodule

// ===== testbench/periph_model.sv
/*
 * Behavioural model of the gated peripheral modules: one data register each.
 * Assumes clock enable, held reset and gated write come from the control block.
 */
module periph_model
    import pin_route_pkg::*;
(
    // Clock
    input wire logic mclk_i,
    // Control from the gates
    input wire logic [NUM_MODULES-1:0] clk_en_i,
    input wire logic [NUM_MODULES-1:0] rst_n_i,
    input wire logic [NUM_MODULES-1:0] wr_i,
    // Register contents seen by the core
    output wire logic [NUM_MODULES-1:0][DATA_W-1:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Each module loads a value of its own, so a swapped index shows
    for (genvar k = 0; k < NUM_MODULES; k++)
    begin : g_mod
        logic [DATA_W-1:0] val;

        always_ff @(posedge mclk_i or negedge rst_n_i[k])
        begin
            if (!rst_n_i[k])
                val <= 8'h00;
            else if (clk_en_i[k] && wr_i[k])
                val <= 8'h5a ^ 8'(k);
        end
        assign rdata_o[k] = val;
    end
endmodule

// ===== testbench/test_pin_route_ctrl.sv
/*
 * Self-checking bench of the module disable and routing lock block.
 * Assumes the package constants and the peripheral model beside it.
 */
module test_pin_route_ctrl
    import pin_route_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk_i;
    logic rst_n_i;
    bus_req_t bus;
    logic [DATA_W-1:0] rd_data_o;
    logic [NUM_MODULES-1:0] sfr_wr_i;
    logic [NUM_MODULES-1:0][DATA_W-1:0] sfr_rdata_i;
    logic [NUM_MODULES-1:0] mod_clk_en_o;
    logic [NUM_MODULES-1:0] mod_rst_n_o;
    logic [NUM_MODULES-1:0] mod_ready_o;
    logic [NUM_MODULES-1:0] sfr_wr_o;
    logic [NUM_MODULES-1:0][DATA_W-1:0] sfr_rdata_o;
    logic lock_o;
    logic [NUM_IN_ROUTES-1:0][IN_SEL_W-1:0] in_sel_o;
    logic [NUM_OUT_ROUTES-1:0][OUT_SEL_W-1:0] out_sel_o;
    logic [NUM_OUT_ROUTES-1:0][OUT_SEL_W-1:0] small_out;
    int num_errors = 0;
    int cmp_count = 0;

    pin_route_ctrl #(.LARGE_VARIANT(1'b1)) uut (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_i(bus), .rd_data_o(rd_data_o),
        .sfr_wr_i(sfr_wr_i), .sfr_rdata_i(sfr_rdata_i), .mod_clk_en_o(mod_clk_en_o),
        .mod_rst_n_o(mod_rst_n_o), .mod_ready_o(mod_ready_o), .sfr_wr_o(sfr_wr_o),
        .sfr_rdata_o(sfr_rdata_o), .lock_o(lock_o), .in_sel_o(in_sel_o),
        .out_sel_o(out_sel_o));

    // Small variant shares the bus; only its output routing is watched
    pin_route_ctrl #(.LARGE_VARIANT(1'b0)) uut_small (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_i(bus), .rd_data_o(),
        .sfr_wr_i(sfr_wr_i), .sfr_rdata_i(sfr_rdata_i), .mod_clk_en_o(),
        .mod_rst_n_o(), .mod_ready_o(), .sfr_wr_o(), .sfr_rdata_o(), .lock_o(),
        .in_sel_o(), .out_sel_o(small_out));

    periph_model model (
        .mclk_i(mclk_i), .clk_en_i(mod_clk_en_o), .rst_n_i(mod_rst_n_o),
        .wr_i(sfr_wr_o), .rdata_o(sfr_rdata_i));

    // Clock
    initial
    begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        bus.wr <= 1'b1;
        bus.addr <= a;
        bus.wdata <= d;
        @(posedge mclk_i);
        bus.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        bus.rd <= 1'b1;
        bus.addr <= a;
        @(posedge mclk_i);
        bus.rd <= 1'b0;
        #1 d = rd_data_o;
    endtask

    task automatic test_reset_values();
        logic [7:0] d;
        rd(OFS_LOCK, d);
        check(d, 8'h00);
        @(posedge mclk_i);
        #1 check(rd_data_o, 8'h00);
        rd(OFS_DIS_LO, d);
        check(d, 8'h00);
        rd(OFS_DIS_HI, d);
        check(d, 8'h00);
        check(mod_clk_en_o, 10'h3ff);
        rd(8'h40, d);
        check(d, 8'h00);
        rd(OFS_RDY_LO, d);
        check(d, 8'hff);
        rd(OFS_RDY_HI, d);
        check(d, 8'h03);
        $display("Test reset values done");
    endtask

    task automatic test_field_widths();
        logic [7:0] d;
        wr(OFS_LOCK, 8'hfe);
        rd(OFS_LOCK, d);
        check(d, 8'h00);
        wr(OFS_IN_BASE, 8'hff);
        rd(OFS_IN_BASE, d);
        check(d, 8'h3f);
        wr(OFS_OUT_BASE, 8'hff);
        rd(OFS_OUT_BASE, d);
        check(d, 8'h1f);
        $display("Test field widths done");
    endtask

    // Lock freezes both routing kinds but not the disable bits
    task automatic test_lock();
        logic [7:0] d;
        wr(OFS_IN_BASE, 8'h15);
        wr(OFS_OUT_BASE + 8'h0d, 8'h0a);
        #1 check(out_sel_o[13], 5'h0a);
        check(small_out[13], 5'h00);
        wr(OFS_LOCK, 8'hff);
        rd(OFS_LOCK, d);
        check(d, 8'h01);
        wr(OFS_IN_BASE, 8'h2a);
        wr(OFS_OUT_BASE + 8'h0d, 8'h11);
        rd(OFS_IN_BASE, d);
        check(d, 8'h15);
        rd(OFS_OUT_BASE + 8'h0d, d);
        check(d, 8'h0a);
        wr(OFS_DIS_HI, 8'h02);
        rd(OFS_DIS_HI, d);
        check(d, 8'h02);
        wr(OFS_DIS_HI, 8'h00);
        wr(OFS_LOCK, 8'h00);
        wr(OFS_IN_BASE, 8'h2a);
        @(posedge mclk_i);
        #1 check(in_sel_o[0], 6'h2a);
        $display("Test lock done");
    endtask

    task automatic test_disable(input int k);
        logic [7:0] a;
        logic [7:0] d;
        int j;
        int n;
        a = (k < 8) ? OFS_DIS_LO : OFS_DIS_HI;
        j = -1;
        for (int i = 0; i < NUM_IN_ROUTES; i++)
            if (j < 0 && IN_OWNER[i] === 4'(k))
                j = i;
        @(posedge mclk_i);
        sfr_wr_i[k] <= 1'b1;
        @(posedge mclk_i);
        sfr_wr_i[k] <= 1'b0;
        repeat (3) @(posedge mclk_i);
        #1 check(sfr_rdata_o[k], 8'h5a ^ 8'(k));
        wr(a, 8'(1 << (k % 8)));
        @(posedge mclk_i);
        #1 check(mod_clk_en_o[k], 1'b0);
        check(mod_rst_n_o[k], 1'b0);
        check(sfr_rdata_o[k], 8'h00);
        check(mod_clk_en_o, 10'h3ff ^ (10'h001 << k));
        @(posedge mclk_i);
        sfr_wr_i[k] <= 1'b1;
        @(posedge mclk_i);
        sfr_wr_i[k] <= 1'b0;
        #1 check(sfr_wr_o[k], 1'b0);
        wr(OFS_IN_BASE + 8'(j), 8'h2b);
        rd(OFS_IN_BASE + 8'(j), d);
        check(d, 8'h00);
        wr(a, 8'h00);
        n = 0;
        do
        begin
            @(posedge mclk_i);
            #1 n++;
        end
        while (mod_ready_o[k] !== 1'b1 && n < 20);
        check(16'(n), 16'(WAKE_CYCLES));
        check(mod_clk_en_o[k], 1'b1);
        check(sfr_rdata_o[k], 8'h00);
        $display("Test disable of module %0d done", k);
    endtask

    // Second reset in mid-run clears lock and disable bits
    task automatic test_mid_reset();
        wr(OFS_LOCK, 8'h01);
        wr(OFS_DIS_LO, 8'hff);
        @(posedge mclk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        #1 check(lock_o, 1'b0);
        check(mod_clk_en_o, 10'h3ff);
        $display("Test mid-run reset done");
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Watchdog far beyond the few hundred cycles the tests need
    initial
    begin
        #200000;
        num_errors++;
        conclude();
    end

    initial
    begin
        rst_n_i = 1'b0;
        bus = '0;
        sfr_wr_i = '0;
        repeat (12) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        test_reset_values();
        test_field_widths();
        test_lock();
        for (int k = 0; k < NUM_MODULES; k++)
            test_disable(k);
        test_mid_reset();
        conclude();
    end
endmodule
